// >>> rtl/byte_fifo.sv
/*
 * small synchronous fifo, valid/ready on both sides, with a flush.
 * assumes one clock domain; depth is a power of two.
 */
`default_nettype none

module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             flush,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   // honest flags straight from the fill count
   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_q] <= in_data;
   end

   // ---------------------------------------------------------------
   // pointers and count
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else if (flush)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
            wr_q <= wr_q + 1'b1;
         if (pop)
            rd_q <= rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

`default_nettype wire

// >>> rtl/codec_host_status_interrupts.sv
/*
 * host control, status and interrupt logic of a delta-modulation voice codec:
 * control registers, encode/decode byte channels, page level report, irq.
 * assumes host pins and the serial encoder bit / level inputs are synchronous
 * to clk; the analog coder and filters sit outside.
 */
`include "codec_regs.svh"
`default_nettype none

module codec_host_status_interrupts #(
   parameter int BIT_DIV    = 32,
   parameter int FIFO_DEPTH = 4
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       cs_n,
   input  wire logic [1:0] addr,
   input  wire logic       rd_wr,
   input  wire logic [7:0] data_in,
   output logic      [7:0] data_out,
   output logic            data_oe,
   output logic            irq_n_out,
   output logic            irq_n_oe,
   input  wire logic       enc_bit_in,
   input  wire logic [3:0] level_ab_in,
   input  wire logic [3:0] level_c_in,
   output logic            dec_bit_out,
   output logic            bit_strobe,
   output logic            route_a_direct,
   output logic            route_b_decoder,
   output logic            powersave,
   output logic            high_sens,
   output logic            enc_fifo_ready
);
   logic [7:0]  first_control_q;
   logic [7:0]  second_control_q;
   logic [7:0]  enc_sr_q;
   logic [2:0]  enc_cnt_q;
   logic        idle_ph_q;
   logic [7:0]  enc_buf_q;
   logic [7:0]  dec_buf_q;
   logic [7:0]  dec_sr_q;
   logic [2:0]  dec_cnt_q;
   logic [7:0]  level_report_q;
   logic [8:0]  page_cnt_q;
   logic        enc_rdy_q, dec_rdy_q, page_rdy_q;
   logic        enc_ovs_q, dec_ovs_q, page_ovs_q;
   logic        cs_prev_q;
   logic        tick;
   logic        acc;
   logic        enc_bit, byte_done, page_end, reload;
   logic [7:0]  enc_byte;
   logic        fifo_valid, fifo_ready, fifo_in_ready;
   logic [7:0]  fifo_data;
   logic        pop, enc_rd, dec_wr, clean;
   codec_pkg::reg_sel_t sel;

   // three-bit select {read, a1, a0} onto a register name
   function automatic codec_pkg::reg_sel_t decode_sel(input logic [2:0] s);
      case (s)
         `SEL_FIRST_CTRL:   decode_sel = codec_pkg::REG_FIRST_CTRL;
         `SEL_SECOND_CTRL:  decode_sel = codec_pkg::REG_SECOND_CTRL;
         `SEL_DEC_BUF:      decode_sel = codec_pkg::REG_DEC_BUF;
         `SEL_EVENT_FLAGS:  decode_sel = codec_pkg::REG_EVENT_FLAGS;
         `SEL_LEVEL_REPORT: decode_sel = codec_pkg::REG_LEVEL_REPORT;
         `SEL_ENC_BUF:      decode_sel = codec_pkg::REG_ENC_BUF;
         default:           decode_sel = codec_pkg::REG_NONE;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // host access decode
   // ---------------------------------------------------------------
   // side effects fire once, on the first cycle of a chip select
   assign acc    = !cs_n && cs_prev_q;
   assign sel    = decode_sel({rd_wr, addr[1], addr[0]});
   assign enc_rd = acc && (sel == codec_pkg::REG_ENC_BUF);
   assign dec_wr = acc && (sel == codec_pkg::REG_DEC_BUF);
   // both conditions gone bad: either buffer access restarts both channels
   assign clean  = enc_ovs_q && dec_ovs_q && (enc_rd || dec_wr);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cs_prev_q <= 1'b1;
      else
         cs_prev_q <= cs_n;
   end

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         first_control_q  <= `FIRST_CTRL_RST;
         second_control_q <= `SECOND_CTRL_RST;
      end
      else if (acc && sel == codec_pkg::REG_FIRST_CTRL)
         first_control_q <= data_in;
      else if (acc && sel == codec_pkg::REG_SECOND_CTRL)
         second_control_q <= data_in;
   end

   // analog switch and mode outputs, registered from the control byte
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         route_a_direct  <= 1'b0;
         route_b_decoder <= 1'b0;
         powersave       <= 1'b0;
         high_sens       <= 1'b0;
      end
      else
      begin
         route_a_direct  <= second_control_q[`SC_ROUTE_A];
         route_b_decoder <= second_control_q[`SC_ROUTE_B];
         powersave       <= second_control_q[`SC_POWERSAVE];
         high_sens       <= second_control_q[`SC_HIGH_SENS];
      end
   end

   // ---------------------------------------------------------------
   // data bit rate
   // ---------------------------------------------------------------
   // bit clock stops in power save, so the coder idles with the analog side
   rate_divider #(
      .DIV (BIT_DIV)
   ) u_div (
      .clk   (clk),
      .rst_n (rst_n),
      .run   (!second_control_q[`SC_POWERSAVE]),
      .tick  (tick)
   );

   // ---------------------------------------------------------------
   // encode shift register
   // ---------------------------------------------------------------
   // idle mode shifts alternating bits; the level inputs still see real audio
   assign enc_bit   = first_control_q[`FC_ENC_IDLE] ? idle_ph_q : enc_bit_in;
   assign enc_byte  = {enc_sr_q[6:0], enc_bit};
   assign byte_done = tick && (enc_cnt_q == 3'h7);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         enc_sr_q  <= 8'h00;
         enc_cnt_q <= 3'h0;
         idle_ph_q <= 1'b1;
      end
      else if (clean)
         enc_cnt_q <= 3'h0;
      else if (tick)
      begin
         enc_sr_q  <= enc_byte;
         enc_cnt_q <= enc_cnt_q + 3'h1;
         idle_ph_q <= !idle_ph_q;
      end
   end

   // ---------------------------------------------------------------
   // encode byte fifo
   // ---------------------------------------------------------------
   // a halted channel lets the fifo fill; bytes past full are lost as they
   // would be on the device, and enc_fifo_ready tells the outside so
   assign fifo_ready = !enc_ovs_q;
   assign pop        = fifo_valid && fifo_ready;

   byte_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .flush     (clean),
      .in_valid  (byte_done),
      .in_ready  (fifo_in_ready),
      .in_data   (enc_byte),
      .out_valid (fifo_valid),
      .out_ready (fifo_ready),
      .out_data  (fifo_data)
   );

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         enc_fifo_ready <= 1'b1;
      else
         enc_fifo_ready <= fifo_in_ready;
   end

   // ---------------------------------------------------------------
   // encode buffer and flags
   // ---------------------------------------------------------------
   // a new byte while the previous one is unread is an overspill: the buffer
   // keeps the old byte and the ready flag drops so the irq goes quiet unless the decode or page ready flag stands
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         enc_buf_q <= 8'h00;
         enc_rdy_q <= 1'b0;
         enc_ovs_q <= 1'b0;
      end
      else if (clean)
      begin
         enc_rdy_q <= 1'b0;
         enc_ovs_q <= 1'b0;
      end
      else
      begin
         if (pop && !(enc_rdy_q && !enc_rd))
         begin
            enc_buf_q <= fifo_data;
            enc_rdy_q <= 1'b1;
         end
         else if (pop)
         begin
            enc_rdy_q <= 1'b0;
            enc_ovs_q <= 1'b1;
         end
         else if (enc_rd)
            enc_rdy_q <= 1'b0;
         if (enc_rd && !pop)
            enc_ovs_q <= 1'b0;
         else if (dec_wr && enc_ovs_q && dec_ovs_q)
            enc_ovs_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // decode shift register, buffer and flags
   // ---------------------------------------------------------------
   assign reload = tick && (dec_cnt_q == 3'h7);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dec_sr_q  <= `IDLE_PATTERN;
         dec_cnt_q <= 3'h0;
      end
      else if (clean)
         dec_cnt_q <= 3'h0;
      else if (reload)
      begin
         dec_cnt_q <= 3'h0;
         // an unwritten buffer or a halted channel shifts idle instead
         if (dec_ovs_q || (dec_rdy_q && !dec_wr))
            dec_sr_q <= `IDLE_PATTERN;
         else
            dec_sr_q <= dec_wr ? data_in : dec_buf_q; // a same-cycle write is not lost
      end
      else if (tick)
      begin
         dec_sr_q  <= {dec_sr_q[6:0], 1'b0};
         dec_cnt_q <= dec_cnt_q + 3'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dec_buf_q <= 8'h00;
         dec_rdy_q <= 1'b0;
         dec_ovs_q <= 1'b0;
      end
      else if (clean)
      begin
         if (dec_wr)
            dec_buf_q <= data_in;
         dec_rdy_q <= 1'b0;
         dec_ovs_q <= 1'b0;
      end
      else
      begin
         if (dec_wr)
            dec_buf_q <= data_in;
         if (reload && !dec_ovs_q && dec_rdy_q && !dec_wr)
         begin
            dec_rdy_q <= 1'b0;
            dec_ovs_q <= 1'b1;
         end
         else if (reload && !dec_ovs_q)
            dec_rdy_q <= 1'b1;
         else if (dec_wr)
            dec_rdy_q <= 1'b0;
         if (dec_wr && dec_ovs_q && !enc_ovs_q)
            dec_ovs_q <= 1'b0;
         else if (enc_rd && dec_ovs_q && enc_ovs_q)
            dec_ovs_q <= 1'b0;
      end
   end

   // decoder source: straight encoder bits, or the decode shifter
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         dec_bit_out <= 1'b0;
      else if (first_control_q[`FC_DEC_SOURCE])
         dec_bit_out <= enc_sr_q[0];
      else
         dec_bit_out <= dec_sr_q[7];
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         bit_strobe <= 1'b0;
      else
         bit_strobe <= tick;
   end

   // ---------------------------------------------------------------
   // page counter and level report
   // ---------------------------------------------------------------
   // page length is (size field + 1) units of 32 encoded bytes
   assign page_end = byte_done &&
      (page_cnt_q == (9'(second_control_q[2:0]) + 9'h1) * `PAGE_UNIT_BYTES - 9'h1);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         page_cnt_q <= 9'h000;
      else if (page_end)
         page_cnt_q <= 9'h000;
      else if (byte_done)
         page_cnt_q <= page_cnt_q + 9'h001;
   end

   // the report updates every page even after an overspill
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         level_report_q <= 8'h00;
      else if (page_end)
         level_report_q <= {level_c_in, level_ab_in};
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         page_rdy_q <= 1'b0;
         page_ovs_q <= 1'b0;
      end
      else
      begin
         if (page_end && page_rdy_q && !(acc && sel == codec_pkg::REG_LEVEL_REPORT))
         begin
            page_rdy_q <= 1'b0;
            page_ovs_q <= 1'b1;
         end
         else if (page_end)
            page_rdy_q <= 1'b1;
         else if (acc && sel == codec_pkg::REG_LEVEL_REPORT)
            page_rdy_q <= 1'b0;
         if (!page_end && acc && (sel == codec_pkg::REG_LEVEL_REPORT ||
                                  sel == codec_pkg::REG_SECOND_CTRL))
            page_ovs_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // read data and interrupt pin
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         data_out <= 8'h00;
         data_oe  <= 1'b0;
      end
      else
      begin
         data_oe <= !cs_n && rd_wr;
         case (sel)
            codec_pkg::REG_EVENT_FLAGS:
               data_out <= {2'b00, page_ovs_q, dec_ovs_q, enc_ovs_q,
                            page_rdy_q, dec_rdy_q, enc_rdy_q};
            codec_pkg::REG_LEVEL_REPORT: data_out <= level_report_q;
            codec_pkg::REG_ENC_BUF:      data_out <= enc_buf_q;
            default:                     data_out <= 8'h00;
         endcase
      end
   end

   // open drain: pull low while any ready flag stands, else release
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_n_out <= 1'b1;
         irq_n_oe  <= 1'b0;
      end
      else
      begin
         irq_n_out <= 1'b0;
         irq_n_oe  <= enc_rdy_q || dec_rdy_q || page_rdy_q;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   enc_ready_set_a: assert property (pop && !enc_rdy_q && !clean |=> enc_rdy_q)
      else $error("encode ready not set on new byte");
   enc_ready_clear_a: assert property (enc_rd && !pop && !clean |=> !enc_rdy_q)
      else $error("encode ready not cleared by read");
   enc_overspill_a: assert property (pop && enc_rdy_q && !enc_rd && !clean
                                     |=> enc_ovs_q && !enc_rdy_q)
      else $error("encode overspill not raised");
   enc_buf_hold_a: assert property (enc_ovs_q && !clean |=> $stable(enc_buf_q))
      else $error("encode buffer changed during overspill");
   dec_idle_fill_a: assert property (reload && dec_ovs_q && !clean
                                     |=> dec_sr_q == `IDLE_PATTERN)
      else $error("decode shifter not idle during overspill");
   level_update_a: assert property (page_end
                    |=> level_report_q == $past({level_c_in, level_ab_in}))
      else $error("level report not loaded at page end");
   page_overspill_a: assert property (page_end && page_rdy_q && !acc
                                      |=> page_ovs_q && !page_rdy_q)
      else $error("page overspill not raised");
   irq_pin_a: assert property (enc_rdy_q |=> irq_n_oe ##0 !irq_n_out)
      else $error("irq not driven while encode ready");
   route_write_a: assert property (acc && sel == codec_pkg::REG_SECOND_CTRL
                     |=> ##1 route_a_direct == $past(data_in[`SC_ROUTE_A], 2))
      else $error("route A not following control write");

   enc_ovs_c: cover property (enc_ovs_q ##1 enc_rd);
   page_done_c: cover property (page_end ##[1:40] (acc && sel == codec_pkg::REG_LEVEL_REPORT));
   clean_start_c: cover property (clean);
endmodule

`default_nettype wire

// >>> rtl/codec_pkg.sv
/*
 * types shared by the codec host interface files.
 * assumes codec_regs.svh holds the numeric constants.
 */
`default_nettype none

package codec_pkg;
   // register selected by one host access
   typedef enum logic [2:0] {
      REG_NONE,
      REG_FIRST_CTRL,
      REG_SECOND_CTRL,
      REG_DEC_BUF,
      REG_EVENT_FLAGS,
      REG_LEVEL_REPORT,
      REG_ENC_BUF
   } reg_sel_t;
endpackage

`default_nettype wire

// >>> rtl/codec_regs.svh
/*
 * register selects, field positions, reset values and fixed patterns of the
 * codec host interface. assumes it is included by the rtl files only.
 */
`ifndef CODEC_REGS_SVH
`define CODEC_REGS_SVH

// ---------------------------------------------------------------
// register selects {read, a1, a0}
// ---------------------------------------------------------------
`define SEL_FIRST_CTRL   3'h0
`define SEL_SECOND_CTRL  3'h1
`define SEL_DEC_BUF      3'h2
`define SEL_EVENT_FLAGS  3'h4
`define SEL_LEVEL_REPORT 3'h5
`define SEL_ENC_BUF      3'h6

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define FC_ENC_IDLE      0
`define FC_DEC_SOURCE    1
`define SC_ROUTE_A       4
`define SC_ROUTE_B       5
`define SC_POWERSAVE     6
`define SC_HIGH_SENS     7

// ---------------------------------------------------------------
// reset values and patterns
// ---------------------------------------------------------------
`define FIRST_CTRL_RST   8'h00
`define SECOND_CTRL_RST  8'h00
`define IDLE_PATTERN     8'haa
`define PAGE_UNIT_BYTES  9'h020

`endif

// >>> rtl/rate_divider.sv
/*
 * divider that gives a one-cycle data bit enable every div clocks.
 * assumes one clock domain; run low holds the count at zero.
 */
`default_nettype none

module rate_divider #(
   parameter int DIV = 32
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic run,
   output logic      tick
);
   localparam int CW = $clog2(DIV);

   logic [CW-1:0] cnt_q;

   // ---------------------------------------------------------------
   // counter and tick
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end
      else if (!run)
      begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end
      else
      begin
         tick  <= (cnt_q == CW'(DIV - 1));
         cnt_q <= (cnt_q == CW'(DIV - 1)) ? '0 : cnt_q + 1'b1;
      end
   end
endmodule

`default_nettype wire

// >>> testbench/host_bus_model.sv
/*
 * host side of the codec bus: resolves the shared data bus and the
 * wired-or interrupt line. assumes the codec is the only device on both.
 */
`default_nettype none

module host_bus_model (
   input  wire logic       clk,
   input  wire logic [7:0] data_out,
   input  wire logic       data_oe,
   input  wire logic       irq_n_out,
   input  wire logic       irq_n_oe,
   output logic      [7:0] host_bus,
   output logic            irq_line
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] last_q;

   // a released bus shows the inverse of its last value, never a stale copy
   always_ff @(posedge clk)
      if (data_oe)
         last_q <= data_out;

   assign host_bus = data_oe ? data_out : ~last_q;

   // pull-up holds the line high unless the device sinks it
   assign irq_line = (irq_n_oe && irq_n_out == 1'b0) ? 1'b0 : 1'b1;
endmodule

`default_nettype wire

// >>> testbench/test_codec_host_status_interrupts.sv
/*
 * self-checking bench of the codec host interface: control bits, flags,
 * overspill and page report. assumes a bit divider of 4 to keep pages short.
 */
`default_nettype none

module test_codec_host_status_interrupts;
   timeunit 1ns;
   timeprecision 1ps;

   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       cs_n = 1'b1;
   logic [1:0] addr = 2'h0;
   logic       rd_wr = 1'b1;
   logic [7:0] data_in = 8'h00;
   logic       enc_bit_in = 1'b1;
   logic [3:0] level_ab_in = 4'h5;
   logic [3:0] level_c_in = 4'ha;
   logic [7:0] data_out, host_bus, rd;
   logic       data_oe, irq_n_out, irq_n_oe, irq_line, dec_bit_out, bit_strobe;
   logic       route_a_direct, route_b_decoder, powersave, high_sens, enc_fifo_ready;
   logic [7:0] sc [4] = '{8'h40, 8'h50, 8'h60, 8'hc0};
   int         mismatches = 0;
   int         n_tests = 0;
   int         n_strobe = 0;

   always #20 clk = ~clk;

   codec_host_status_interrupts #(.BIT_DIV(4), .FIFO_DEPTH(4)) i_codec_host_status_interrupts (
      .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .addr(addr), .rd_wr(rd_wr),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
      .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .enc_bit_in(enc_bit_in),
      .level_ab_in(level_ab_in), .level_c_in(level_c_in), .dec_bit_out(dec_bit_out),
      .bit_strobe(bit_strobe), .route_a_direct(route_a_direct),
      .route_b_decoder(route_b_decoder), .powersave(powersave),
      .high_sens(high_sens), .enc_fifo_ready(enc_fifo_ready));

   host_bus_model i_host_bus_model (
      .clk(clk), .data_out(data_out), .data_oe(data_oe), .irq_n_out(irq_n_out),
      .irq_n_oe(irq_n_oe), .host_bus(host_bus), .irq_line(irq_line));

   // -----------------------------------------------------------
   // checking and bus tasks
   // -----------------------------------------------------------
   task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task results();
      $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // one access: select held two edges so read data is settled, then released
   task acc(input logic rw, input logic [1:0] a, input logic [7:0] wd);
      @(negedge clk);
      cs_n = 1'b0;
      rd_wr = rw;
      addr = a;
      data_in = wd;
      @(negedge clk);
      @(negedge clk);
      rd = host_bus;
      cs_n = 1'b1;
      @(negedge clk);
   endtask

   // polls the flag register; a flag that never comes ends the run
   task wait_flag(input int b, input int limit);
      int i;
      for (i = 0; i < limit; i++)
      begin
         acc(1'b1, 2'h0, 8'h00);
         if (rd[b] === 1'b1)
            return;
      end
      chk("flag wait", {7'h00, rd[b]}, 8'h01);
      results();
   endtask

   // -----------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------
   initial
   begin
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      chk("irq line", {7'h00, irq_line}, 8'h01);
      chk("fifo ready", {7'h00, enc_fifo_ready}, 8'h01);
      // power save first, so the bit clock stops before any byte forms
      for (int i = 0; i < 4; i++)
      begin
         acc(1'b0, 2'h1, sc[i]);
         @(negedge clk);
         chk("control", {4'h0, high_sens, powersave, route_b_decoder, route_a_direct},
             sc[i] >> 4);
      end
      // power save holds the bit clock, so no strobe may appear
      repeat (16) @(negedge clk) n_strobe += bit_strobe;
      chk("strobes off", 8'(n_strobe), 8'h00);
      acc(1'b1, 2'h0, 8'h00);
      chk("flags idle", rd, 8'h00);
      acc(1'b1, 2'h3, 8'h00);
      chk("unmapped", rd, 8'h00);
      acc(1'b0, 2'h0, 8'h02);
      acc(1'b0, 2'h1, 8'h00);
      // one strobe every four clocks once running
      n_strobe = 0;
      repeat (16) @(negedge clk) n_strobe += bit_strobe;
      chk("strobes on", 8'(n_strobe), 8'h04);
      wait_flag(0, 40);
      chk("irq line", {7'h00, irq_line}, 8'h00);
      chk("decoder source", {7'h00, dec_bit_out}, 8'h01);
      acc(1'b1, 2'h2, 8'h00);
      chk("encode byte", rd, 8'hff);
      acc(1'b1, 2'h0, 8'h00);
      chk("encode ready", rd & 8'h01, 8'h00);
      // leave the encoder unserviced for several bytes
      repeat (120) @(negedge clk);
      acc(1'b1, 2'h0, 8'h00);
      chk("encode overspill", rd & 8'h09, 8'h08);
      acc(1'b1, 2'h2, 8'h00);
      acc(1'b1, 2'h0, 8'h00);
      chk("overspill cleared", rd & 8'h18, 8'h00);
      wait_flag(1, 40);
      acc(1'b0, 2'h2, 8'h3c);
      acc(1'b1, 2'h0, 8'h00);
      chk("decode ready", rd & 8'h02, 8'h00);
      wait_flag(2, 800);
      acc(1'b1, 2'h1, 8'h00);
      chk("level report", rd, 8'ha5);
      acc(1'b1, 2'h0, 8'h00);
      chk("page ready", rd & 8'h04, 8'h00);
      wait_flag(5, 1600);
      acc(1'b0, 2'h1, 8'h00);
      acc(1'b1, 2'h0, 8'h00);
      chk("page overspill", rd & 8'h20, 8'h00);
      // both channels overspilled: idle mode, then a restart by encode read
      acc(1'b0, 2'h0, 8'h01);
      acc(1'b1, 2'h2, 8'h00);
      wait_flag(0, 40);
      acc(1'b1, 2'h2, 8'h00);
      chk("idle pattern", (rd ^ (rd >> 1)) & 8'h7f, 8'h7f);
      results();
   end
endmodule

`default_nettype wire
